// ==== verilog/ctes_top.sv ====
// Purpose: Charge-time unit edge-source selection with AXI4-Lite registers
// Assumes: 125 MHz sys_clk_i, asynchronous active-high reset_i
// Notes:   Edge status flags are sticky; source inputs are synchronised
`timescale 1ns/100ps
module ctes_top
  import ctes_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Edge sources
  input  wire logic        timer_one_i,
  input  wire logic        compare_unit_one_i,
  input  wire logic [8:1]  ext_edge_pin_i,
  input  wire logic [3:1]  capture_unit_i,
  input  wire logic        comparator_one_output_i,
  input  wire logic        comparator_two_output_i,
  // Analog control and interrupt
  output logic             converter_cap_discharge_o,
  output logic             pulse_delay_enable_o,
  output logic             irq_o
);

  // ****************************************
  // Register state
  // ****************************************
  logic [31:0] ctrl_ff,     nxt_ctrl;
  logic [CTES_NUM_EVT-1:0] stat_ff, nxt_stat;
  logic [CTES_NUM_EVT-1:0] ien_ff,  nxt_ien;
  logic        aw_got_ff,   nxt_aw_got;
  logic        w_got_ff,    nxt_w_got;
  logic [7:0]  awaddr_ff,   nxt_awaddr;
  logic [31:0] wdata_ff,    nxt_wdata;
  logic [3:0]  wstrb_ff,    nxt_wstrb;
  logic        bvalid_ff,   nxt_bvalid;
  logic [1:0]  bresp_ff,    nxt_bresp;
  logic        rvalid_ff,   nxt_rvalid;
  logic [31:0] rdata_ff,    nxt_rdata;
  logic [1:0]  rresp_ff,    nxt_rresp;

  logic        wr_fire;
  logic        rd_fire;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [15:0] src_vec;
  logic        evt_one;
  logic        evt_two;

  // ****************************************
  // Source map by code
  // ****************************************
  // Bit index equals the source code; code F is driven low
  assign src_vec = {1'b0,
                    comparator_two_output_i,
                    comparator_one_output_i,
                    capture_unit_i[3:1],
                    ext_edge_pin_i[8:3],
                    ext_edge_pin_i[1],
                    ext_edge_pin_i[2],
                    compare_unit_one_i,
                    timer_one_i};

  // Edge one path uses the control fields
  ctes_edge_det u_edge_one (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .src_sel_i   (ctrl_ff[CTES_E1_SRC_HI:CTES_E1_SRC_LO]),
    .edge_mode_i (ctrl_ff[CTES_E1_TYPE_BIT]),
    .polarity_i  (ctrl_ff[CTES_E1_POL_BIT]),
    .src_i       (src_vec),
    .event_o     (evt_one)
  );

  // Edge two path: always edge-sensitive, rising, own source field
  ctes_edge_det u_edge_two (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .src_sel_i   (ctrl_ff[CTES_E2_SRC_HI:CTES_E2_SRC_LO]),
    .edge_mode_i (1'b1),
    .polarity_i  (1'b1),
    .src_i       (src_vec),
    .event_o     (evt_two)
  );

  // ****************************************
  // AXI4-Lite handshakes
  // ****************************************
  // Address and data are latched independently, in either order
  assign s_axi_awready_o = ~aw_got_ff & ~bvalid_ff;
  assign s_axi_wready_o  = ~w_got_ff  & ~bvalid_ff;
  assign s_axi_arready_o = ~rvalid_ff;
  assign wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign rd_fire = s_axi_arvalid_i & ~rvalid_ff;

  // Byte-lane mask
  always_comb begin
    wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    wval  = (ctrl_ff & ~wmask) | (wdata_ff & wmask);
  end

  // Next-state for bus and registers
  always_comb begin
    nxt_aw_got = aw_got_ff;
    nxt_w_got  = w_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata  = wdata_ff;
    nxt_wstrb  = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    nxt_ctrl   = ctrl_ff;
    nxt_stat   = stat_ff;
    nxt_ien    = ien_ff;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      nxt_w_got = 1'b1;
      nxt_wdata = s_axi_wdata_i;
      nxt_wstrb = s_axi_wstrb_i;
    end
    // Software writes first, hardware events override below
    if (wr_fire) begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = 2'b00;
      unique case ({awaddr_ff[7:2], 2'b00})
        CTES_CTRL_OFS: nxt_ctrl = wval & CTES_CTRL_MASK;
        CTES_STAT_OFS: ;
        CTES_CLR_OFS:  nxt_stat = stat_ff & ~wdata_ff[CTES_NUM_EVT-1:0];
        CTES_EN_OFS:   nxt_ien  = wdata_ff[CTES_NUM_EVT-1:0];
        default:       nxt_bresp = 2'b10;
      endcase
    end
    if (bvalid_ff && s_axi_bready_i) begin
      nxt_bvalid = 1'b0;
    end
    // Hardware sets win over a same-cycle clear
    if (evt_one) begin
      nxt_ctrl[CTES_E1_FLAG_BIT] = 1'b1;
      nxt_stat[0] = 1'b1;
    end
    if (evt_two) begin
      nxt_ctrl[CTES_E2_FLAG_BIT] = 1'b1;
      nxt_stat[1] = 1'b1;
    end
    if (rd_fire) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = 2'b00;
      unique case ({s_axi_araddr_i[7:2], 2'b00})
        CTES_CTRL_OFS: nxt_rdata = ctrl_ff;
        CTES_STAT_OFS: nxt_rdata = {30'h0, stat_ff};
        CTES_CLR_OFS:  nxt_rdata = 32'h0;
        CTES_EN_OFS:   nxt_rdata = {30'h0, ien_ff};
        default: begin
          nxt_rdata = 32'h0;
          nxt_rresp = 2'b10;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready_i) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= 2'b00;
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0;
      rresp_ff  <= 2'b00;
      ctrl_ff   <= CTES_CTRL_RST;
      stat_ff   <= 2'b00;
      ien_ff    <= 2'b00;
    end else begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff  <= nxt_w_got;
      awaddr_ff <= nxt_awaddr;
      wdata_ff  <= nxt_wdata;
      wstrb_ff  <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
      ctrl_ff   <= nxt_ctrl;
      stat_ff   <= nxt_stat;
      ien_ff    <= nxt_ien;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Sink enable straight from the register; sampling phase is software's job
  assign converter_cap_discharge_o = ctrl_ff[CTES_DISCH_BIT];
  assign pulse_delay_enable_o      = ctrl_ff[CTES_PDLY_EN_BIT];
  assign irq_o          = |(stat_ff & ien_ff);
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o  = bresp_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o  = rdata_ff;
  assign s_axi_rresp_o  = rresp_ff;

  // ****************************************
  // Checks
  // ****************************************
  a_flag_two_set: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    evt_two |=> ctrl_ff[CTES_E2_FLAG_BIT])
    else $error("edge two flag not set");

  a_flag_wins: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (evt_two && wr_fire) |=> stat_ff[1])
    else $error("edge two event lost on clear");

  a_disch_follow: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (wr_fire && awaddr_ff == CTES_CTRL_OFS && wstrb_ff[1])
      |=> converter_cap_discharge_o == $past(wdata_ff[CTES_DISCH_BIT]))
    else $error("discharge output does not follow write");

  a_src_timer: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (ctrl_ff[CTES_E1_SRC_HI:CTES_E1_SRC_LO] == CTES_SRC_TIMER)
      |-> src_vec[CTES_SRC_TIMER] == timer_one_i)
    else $error("timer source map wrong");

  a_src_cmp_two: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    src_vec[CTES_SRC_CMPA2] == comparator_two_output_i && !src_vec[CTES_SRC_RSVD])
    else $error("comparator two map wrong");

  a_irq_level: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (stat_ff[0] && ien_ff[0]) |-> irq_o)
    else $error("interrupt not raised");

  // Edge one event lands in both copies of its flag
  a_flag_one_set: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    evt_one |=> (ctrl_ff[CTES_E1_FLAG_BIT] && stat_ff[0]))
    else $error("edge one flag not set");

  // Interrupt stays low without an enabled pending bit
  a_irq_quiet: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !(|(stat_ff & ien_ff)) |-> !irq_o)
    else $error("interrupt raised with nothing pending");

  // Unimplemented control bits never hold a one, even after event sets
  a_ctrl_rsvd: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (ctrl_ff & ~CTES_CTRL_MASK) == 32'h0000_0000)
    else $error("unimplemented control bit set");

  // Accepted read address gets its answer on the next cycle
  a_rd_answer: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (s_axi_arvalid_i && s_axi_arready_o) |=> s_axi_rvalid_o)
    else $error("read answer late");

  // Reads outside the map return an error and zero data
  a_rd_slverr: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[7:4] != 4'h0)
      |=> (rresp_ff == 2'b10 && rdata_ff == 32'h0000_0000))
    else $error("unmapped read not refused");

  // Writes outside the map are answered with an error
  a_wr_slverr: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (wr_fire && awaddr_ff[7:4] != 4'h0) |=> (bvalid_ff && bresp_ff == 2'b10))
    else $error("unmapped write not refused");

endmodule

// ==== verilog/ctes_pkg.sv ====
// Purpose: Constants for the charge-time edge-select block
// Assumes: 32-bit AXI4-Lite register access, one clock
// Notes:   Field positions follow the control register layout
package ctes_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] CTES_CTRL_OFS  = 8'h00;
  localparam logic [7:0] CTES_STAT_OFS  = 8'h04;
  localparam logic [7:0] CTES_CLR_OFS   = 8'h08;
  localparam logic [7:0] CTES_EN_OFS    = 8'h0C;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTES_E1_TYPE_BIT   = 31;
  localparam int CTES_E1_POL_BIT    = 30;
  localparam int CTES_E1_SRC_HI     = 29;
  localparam int CTES_E1_SRC_LO     = 26;
  localparam int CTES_E2_FLAG_BIT   = 25;
  localparam int CTES_E1_FLAG_BIT   = 24;
  localparam int CTES_E2_SRC_HI     = 21;
  localparam int CTES_E2_SRC_LO     = 18;
  localparam int CTES_PDLY_EN_BIT   = 12;
  localparam int CTES_DISCH_BIT     = 9;
  localparam logic [31:0] CTES_CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] CTES_CTRL_MASK = 32'hFFFC_BFFF;

  // Status bits: 0 edge one, 1 edge two
  localparam int CTES_NUM_EVT = 2;

  // Source codes
  localparam logic [3:0] CTES_SRC_TIMER = 4'h0;
  localparam logic [3:0] CTES_SRC_CMP1  = 4'h1;
  localparam logic [3:0] CTES_SRC_PIN2  = 4'h2;
  localparam logic [3:0] CTES_SRC_PIN1  = 4'h3;
  localparam logic [3:0] CTES_SRC_PIN3  = 4'h4;
  localparam logic [3:0] CTES_SRC_PIN8  = 4'h9;
  localparam logic [3:0] CTES_SRC_CAP1  = 4'hA;
  localparam logic [3:0] CTES_SRC_CAP3  = 4'hC;
  localparam logic [3:0] CTES_SRC_CMPA1 = 4'hD;
  localparam logic [3:0] CTES_SRC_CMPA2 = 4'hE;
  localparam logic [3:0] CTES_SRC_RSVD  = 4'hF;

endpackage

// ==== verilog/ctes_edge_det.sv ====
// Purpose: Source select, synchroniser and edge qualifier for one edge input
// Assumes: Sources are asynchronous to sys_clk_i
// Notes:   Event pulse is one cycle after the qualified sample
`timescale 1ns/100ps
module ctes_edge_det
  import ctes_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  // Configuration
  input  wire logic [3:0]  src_sel_i,
  input  wire logic        edge_mode_i,
  input  wire logic        polarity_i,
  // Raw sources
  input  wire logic [15:0] src_i,
  // Qualified event
  output logic             event_o
);

  logic       raw_sel;
  logic [2:0] sync_ff;
  logic [2:0] nxt_sync;
  logic       event_ff;
  logic       nxt_event;
  logic       active;
  logic       prev_active;

  // Reserved code selects a constant low input
  always_comb begin
    raw_sel = (src_sel_i == CTES_SRC_RSVD) ? 1'b0 : src_i[src_sel_i];
  end

  // Two-stage synchroniser plus a history stage for edge detection
  always_comb begin
    nxt_sync = {sync_ff[1:0], raw_sel};
    active      = polarity_i ? sync_ff[1] : ~sync_ff[1];
    prev_active = polarity_i ? sync_ff[2] : ~sync_ff[2];
    // Edge mode fires on entry into the active level only
    nxt_event = edge_mode_i ? (active & ~prev_active) : active;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync_ff  <= 3'h0;
      event_ff <= 1'b0;
    end else begin
      sync_ff  <= nxt_sync;
      event_ff <= nxt_event;
    end
  end

  assign event_o = event_ff;

  // Edge mode: a pulse needs an inactive-to-active transition before it
  a_edge_qualify: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (edge_mode_i && $stable(edge_mode_i) && $stable(polarity_i) && event_ff)
      |-> ($past(sync_ff[1]) == polarity_i && $past(sync_ff[2]) != polarity_i))
    else $error("edge event without qualifying transition");

  // Level mode with falling polarity follows the inverted sample
  // Skip the first edge after release: event_ff still holds its reset value there
  a_level_follow: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (!$past(reset_i) && $past(!edge_mode_i) && $past(!polarity_i))
      |-> (event_ff == !$past(sync_ff[1])))
    else $error("level event does not follow input");

endmodule

// ==== dv/ctes_src_model.sv ====
// Purpose: Model of the on-chip event sources feeding the edge selector
// Assumes: Sources are active-high levels, indexed by source code
// Notes:   Unselected sources rest low, as idle on-chip events do
`timescale 1ns/100ps
module ctes_src_model (
  // Clock
  input  wire logic        sys_clk_i,
  // Bench command
  input  wire logic [3:0]  sel_i,
  input  wire logic        lvl_i,
  // Source lines by code
  output logic      [15:0] src_o
);
  // ****************************************
  // Source drive
  // ****************************************
  // Registered, so levels move just after an edge like real event logic
  always_ff @(posedge sys_clk_i) begin
    src_o        <= 16'h0000;
    src_o[sel_i] <= lvl_i;
  end
endmodule

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench for the charge-time edge selector
// Assumes: AXI4-Lite master in the bench, source model on the far side
// Notes:   Bus answers are checked by a monitor against a queue of notes
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module testbench
  import ctes_pkg::*;
;
  typedef struct {logic [31:0] d; logic [1:0] r; bit rd;} ctes_exp_t;
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, lvl, disch, pdly, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb, sel;
  logic [1:0]  bresp, rresp;
  logic [15:0] src;
  ctes_exp_t   expq[$];
  int          fail_count, compares;

  ctes_top DUT (.sys_clk_i(clk), .reset_i(rst), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .timer_one_i(src[0]), .compare_unit_one_i(src[1]),
    .ext_edge_pin_i({src[9:4], src[2], src[3]}), .capture_unit_i(src[12:10]),
    .comparator_one_output_i(src[13]), .comparator_two_output_i(src[14]),
    .converter_cap_discharge_o(disch), .pulse_delay_enable_o(pdly), .irq_o(irq));

  ctes_src_model u_src (.sys_clk_i(clk), .sel_i(sel), .lvl_i(lvl), .src_o(src));

  // ****************************************
  // Clock and answer monitor
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Oldest note is matched to each bus answer as it is taken
  always @(posedge clk) begin
    ctes_exp_t x;
    if ((rvalid && rready) || (bvalid && bready)) begin
      if (expq.size() == 0) begin
        fail_count++;
        $display("MISMATCH answer exp=none got=answer");
      end else begin
        x = expq.pop_front();
        if (x.rd) `CHK("rdata", x.d, rdata)
        `CHK("resp", x.r, (x.rd ? rresp : bresp))
      end
    end
  end

  task automatic wrap_up();
    $display("Counts: compares=%0d mismatches=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // One bus transfer; holds each channel until its handshake edge
  task automatic bus(input bit rd, input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    int n;
    @(posedge clk);
    expq.push_back('{d, r, rd});
    if (rd) begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end else begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if ((rd && rvalid) || (!rd && bvalid)) break;
    end
    rready <= 1'b0;
    bready <= 1'b0;
    if (n == 100) begin
      fail_count++;
      $display("MISMATCH bus_wait exp=answer got=timeout");
      wrap_up();
    end
  endtask

  // Edge one: preset source, clear flags, move source, read status
  task automatic edge1(input logic [3:0] c, input bit m, p, pre, post,
                       input logic [31:0] e);
    sel <= c;
    lvl <= pre;
    bus(0, CTES_CTRL_OFS, {m, p, c, 26'h0}, 2'b00);
    repeat (8) @(posedge clk);
    bus(0, CTES_CLR_OFS, 32'h3, 2'b00);
    lvl <= post;
    repeat (8) @(posedge clk);
    bus(1, CTES_STAT_OFS, e, 2'b00);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready, lvl} = 7'h40;
    {awaddr, araddr, wdata, sel} = '0;
    wstrb = 4'hF;
    v = $urandom(89);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Reset leaves edge one level-sensitive on falling polarity, so the idle-low
    // timer line is active at once: the control read still sees the reset word,
    // while the status read already shows edge one pending
    bus(1, CTES_CTRL_OFS, CTES_CTRL_RST, 2'b00);
    bus(1, CTES_STAT_OFS, 32'h1, 2'b00);
    bus(1, 8'h10, 32'h0, 2'b10);
    bus(0, 8'h14, 32'h0, 2'b10);
    $display("Test reset_map done");
    // Rising polarity with idle-low sources keeps random levels quiet
    v = ($urandom & ~32'h0300_0000) | 32'h4000_0000;
    bus(0, CTES_CTRL_OFS, v, 2'b00);
    // Level events in flight at the write set the edge one flag again
    bus(1, CTES_CTRL_OFS, (v & CTES_CTRL_MASK) | (32'h1 << CTES_E1_FLAG_BIT), 2'b00);
    `CHK("discharge", v[CTES_DISCH_BIT], disch)
    `CHK("pulse_delay", v[CTES_PDLY_EN_BIT], pdly)
    $display("Test random_ctrl done");
    edge1(4'h5, 1, 1, 1, 1, 32'h0);
    edge1(4'h5, 0, 1, 1, 1, 32'h1);
    edge1(4'h6, 1, 0, 1, 0, 32'h1);
    edge1(4'h6, 1, 0, 0, 1, 32'h0);
    $display("Test mode_polarity done");
    // Edge two also watches the timer (source field zero), so code 0 sets both
    for (int c = 0; c < 16; c++) edge1(c[3:0], 1, 1, 0, 1, {30'h0, c == 0, c != 15});
    $display("Test source_codes done");
    sel <= 4'hE;
    lvl <= 1'b0;
    bus(0, CTES_CTRL_OFS, 32'hC038_1200, 2'b00);
    `CHK("pulse_delay", 1'b1, pdly)
    `CHK("discharge", 1'b1, disch)
    repeat (8) @(posedge clk);
    bus(0, CTES_CLR_OFS, 32'h3, 2'b00);
    bus(0, CTES_EN_OFS, 32'h2, 2'b00);
    `CHK("irq_idle", 1'b0, irq)
    lvl <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("irq_set", 1'b1, irq)
    bus(1, CTES_STAT_OFS, 32'h2, 2'b00);
    bus(1, CTES_CTRL_OFS, 32'hC238_1200, 2'b00);
    bus(0, CTES_EN_OFS, 32'h0, 2'b00);
    repeat (2) @(posedge clk);
    `CHK("irq_masked", 1'b0, irq)
    bus(0, CTES_EN_OFS, 32'h2, 2'b00);
    repeat (2) @(posedge clk);
    `CHK("irq_unmasked", 1'b1, irq)
    bus(0, CTES_CLR_OFS, 32'h2, 2'b00);
    repeat (2) @(posedge clk);
    `CHK("irq_cleared", 1'b0, irq)
    bus(1, CTES_STAT_OFS, 32'h0, 2'b00);
    bus(1, CTES_CLR_OFS, 32'h0, 2'b00);
    $display("Test edge_two_irq done");
    wrap_up();
  end
endmodule
